// [bench/buh_host_model.sv]
// Host microcontroller model: serial 8N1 sender and receiver at a set bit time.
// Assumes the device's transmit line idles high and shares i_clk with the bench.
module buh_host_model (
  // Clock
  input  wire logic i_clk,
  // Device pins
  input  wire logic i_dev_tx,
  input  wire logic i_dev_full,
  // Host transmit line
  output logic      o_host_tx
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned bit_cyc = 10417;
  logic [7:0]  rx_q[$];

  initial o_host_tx = 1'b1;

  // Start, 8 data LSB first, stop; waits while the device reports no room
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frm;
    frm = {1'b1, b, 1'b0};
    while (i_dev_full === 1'b1) @(negedge i_clk);
    for (int i = 0; i < 10; i++) begin
      o_host_tx = frm[i];
      repeat (bit_cyc) @(negedge i_clk);
    end
  endtask

  // Receiver samples mid-bit, so a slight skew of the device's start is harmless
  always begin : rx_proc
    logic [7:0] b;
    @(negedge i_dev_tx);
    repeat (bit_cyc / 2) @(negedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(negedge i_clk);
      b[i] = i_dev_tx;
    end
    repeat (bit_cyc) @(negedge i_clk);
    rx_q.push_back(b);
  end
endmodule // buh_host_model

// [bench/testbench.sv]
// Self-checking bench for the host control block of the serial bridge.
// Assumes the host model is compiled first; one 100 MHz clock, sync reset.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import buh_pkg::*;

  logic       i_clk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       i_sleep_control_in = 1'b1;
  logic       i_serial_enable_in = 1'b1;
  logic       i_link_up = 1'b0;
  logic       i_link_ready = 1'b0;
  logic       host_tx, o_uart_tx, o_link_indicator_out, o_buffer_full;
  logic       o_link_valid, o_commit, tx_low_seen = 1'b0;
  logic [7:0] o_link_data;
  logic [2:0] o_baud_code;
  logic [7:0] link_q[$];
  logic [7:0] sent_q[$];
  int         err_count = 0;
  int         checked = 0;
  int         cyc = 0;
  int         commits = 0;
  int         seed = 36;

  always #5 i_clk = ~i_clk;

  buh_ctrl uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sleep_control_in(i_sleep_control_in),
    .i_serial_enable_in(i_serial_enable_in), .i_uart_rx(host_tx), .o_uart_tx(o_uart_tx),
    .o_link_indicator_out(o_link_indicator_out), .o_buffer_full(o_buffer_full),
    .i_link_up(i_link_up), .i_link_ready(i_link_ready), .o_link_valid(o_link_valid),
    .o_link_data(o_link_data), .o_baud_code(o_baud_code), .o_commit(o_commit));

  buh_host_model host (.i_clk(i_clk), .i_dev_tx(o_uart_tx), .i_dev_full(o_buffer_full),
    .o_host_tx(host_tx));

  // Monitors; the ceiling is long because 9600 baud has no shortening parameter
  always @(posedge i_clk) begin
    cyc++;
    if (o_link_valid === 1'b1 && i_link_ready) link_q.push_back(o_link_data);
    if (o_commit === 1'b1) commits++;
    if (o_uart_tx !== 1'b1) tx_low_seen = 1'b1;
    if (cyc == 7_000_000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic send_cmd(input logic [71:0] c);
    for (int i = 0; i < 9; i++) host.send_byte(c[71-8*i -: 8]);
  endtask

  // Bounded wait for n reply bytes, compared with the low n bytes of rsp, most significant first
  task automatic get_rsp(input logic [79:0] rsp, input int n);
    int k;
    k = 0;
    while (host.rx_q.size() < n && k < (n + 6) * 10 * host.bit_cyc) begin
      @(negedge i_clk);
      k++;
    end
    check("reply length", host.rx_q.size(), n);
    for (int i = 0; i < n && i < host.rx_q.size(); i++)
      check("reply byte", host.rx_q[i], rsp[8*n-1-8*i -: 8]);
    host.rx_q.delete();
  endtask

  // Random payload bytes; rec keeps them as expected link traffic
  task automatic pass_bytes(input int n, input bit rec);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      if (rec) sent_q.push_back(b);
      host.send_byte(b);
    end
    cycles(50);
  endtask

  task automatic cmp_link();
    check("link count", link_q.size(), sent_q.size());
    for (int i = 0; i < sent_q.size() && i < link_q.size(); i++)
      check("link byte", link_q[i], sent_q[i]);
    link_q.delete();
    sent_q.delete();
  endtask

  task automatic end_sim();
    $display("checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    cycles(6);
    check("reset outs", {o_uart_tx, o_link_indicator_out, o_buffer_full, o_link_valid,
      o_commit, o_baud_code}, 8'h80);
    i_rst_b = 1'b1;
    i_link_up = 1'b1;
    cycles(20);
    check("ind asleep", o_link_indicator_out, 1'b0);
    i_link_up = 1'b0;
    i_sleep_control_in = 1'b0;
    i_serial_enable_in = 1'b0;
    cycles(20);
    check("ind adv", o_link_indicator_out, 1'b0);
    send_cmd({"TTM:BPS-", 8'h02});
    get_rsp(RSP_OK, OK_LEN);
    check("baud pending", o_baud_code, 3'h0);
    send_cmd("TTM:RSSYS");
    cycles(6 * host.bit_cyc);
    check("reset reply", host.rx_q.size(), 0);
    check("commit", commits, 1);
    check("baud new", o_baud_code, 3'h2);
    host.bit_cyc = BIT_CYC_2;
    send_cmd({"TTM:BPS-", 8'h05});
    get_rsp(RSP_ERR, ERR_LEN);
    send_cmd("TTM:XYZ-1");
    get_rsp(RSP_ERR, ERR_LEN);
    send_cmd("TTM:MAC-?");
    get_rsp({32'h0000_0000, MAC_ADDR_RST}, MAC_LEN);
    i_link_up = 1'b1;
    i_link_ready = 1'b1;
    cycles(20);
    check("ind conn", o_link_indicator_out, 1'b1);
    i_serial_enable_in = 1'b1;
    cycles(20);
    tx_low_seen = 1'b0;
    pass_bytes(1, 1'b0);
    check("drop port off", link_q.size(), 0);
    check("tx idle", tx_low_seen, 1'b0);
    i_serial_enable_in = 1'b0;
    i_sleep_control_in = 1'b1;
    cycles(20);
    check("ind sleep", o_link_indicator_out, 1'b0);
    pass_bytes(1, 1'b0);
    check("drop asleep", link_q.size(), 0);
    i_sleep_control_in = 1'b0;
    cycles(20);
    pass_bytes(3, 1'b1);
    cmp_link();
    i_link_ready = 1'b0;
    pass_bytes(LINK_FIFO_FULL, 1'b1);
    check("full", o_buffer_full, 1'b1);
    i_link_ready = 1'b1;
    cycles(50);
    check("full clear", o_buffer_full, 1'b0);
    cmp_link();
    end_sim();
  end
endmodule // testbench

// [design/buh_ctrl.sv]
// Host-facing control and command interpreter of a wireless serial bridge.
// Assumes pins arrive asynchronously; the radio side is a plain byte port.
module buh_ctrl (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Host control pins
  input  wire logic        i_sleep_control_in,
  input  wire logic        i_serial_enable_in,
  input  wire logic        i_uart_rx,
  output logic             o_uart_tx,
  output logic             o_link_indicator_out,
  output logic             o_buffer_full,
  // Radio side
  input  wire logic        i_link_up,
  input  wire logic        i_link_ready,
  output logic             o_link_valid,
  output logic [7:0]       o_link_data,
  // Settings state
  output logic [2:0]       o_baud_code,
  output logic             o_commit
);
  import buh_pkg::*;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] slp_s_q, sen_s_q, rx_s_q, lnk_s_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      slp_s_q <= 2'b11; sen_s_q <= 2'b11; rx_s_q <= 2'b11; lnk_s_q <= 2'b00;
    end else begin
      slp_s_q <= {slp_s_q[0], i_sleep_control_in};
      sen_s_q <= {sen_s_q[0], i_serial_enable_in};
      rx_s_q  <= {rx_s_q[0], i_uart_rx};
      lnk_s_q <= {lnk_s_q[0], i_link_up};
    end
  end
  wire sleep_w = slp_s_q[1];
  wire sen_w   = sen_s_q[1];
  wire link_w  = lnk_s_q[1];

  // --------------------------------------------------------------------------
  // Mode machine
  // --------------------------------------------------------------------------
  buh_mode_t mode_q, mode_d;
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      BUH_SLEEP: if (!sleep_w) mode_d = BUH_ADV;
      BUH_ADV:   if (sleep_w) mode_d = BUH_SLEEP;
                 else if (link_w) mode_d = BUH_CONN;
      default:   if (sleep_w) mode_d = BUH_SLEEP;
                 else if (!link_w) mode_d = BUH_ADV;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) mode_q <= BUH_SLEEP;
    else          mode_q <= mode_d;
  end

  // Serial-enable only matters while awake
  wire uart_on_w = !sleep_w && !sen_w;
  wire cmd_mode_w = uart_on_w && (mode_q == BUH_ADV);
  wire pass_w     = uart_on_w && (mode_q == BUH_CONN);

  // --------------------------------------------------------------------------
  // Settings: live baud code and commit pulse
  // --------------------------------------------------------------------------
  logic [2:0] baud_q, baud_pend_q;
  logic       commit_q;
  logic [BAUD_DIV_W-1:0] bit_cyc_w;
  assign bit_cyc_w = (baud_q == 3'h1) ? BIT_CYC_1 :
                     (baud_q == 3'h2) ? BIT_CYC_2 :
                     (baud_q == 3'h3) ? BIT_CYC_3 :
                     (baud_q == 3'h4) ? BIT_CYC_4 : BIT_CYC_0;

  // --------------------------------------------------------------------------
  // UART core
  // --------------------------------------------------------------------------
  buh_uart_if uif ();
  logic       tx_valid_w;
  logic [7:0] tx_data_w;
  assign uif.bit_cyc  = bit_cyc_w;
  assign uif.enable   = uart_on_w;
  assign uif.tx_valid = tx_valid_w;
  assign uif.tx_data  = tx_data_w;
  logic tx_pin_w;
  buh_uart u_uart (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_rx    (rx_s_q[1]),
    .o_tx    (tx_pin_w),
    .u       (uif.core)
  );

  // --------------------------------------------------------------------------
  // Command buffer: one flip-flop byte per index
  // --------------------------------------------------------------------------
  logic [7:0]           cbuf_q [CMD_MAX];
  logic [CMD_IDX_W-1:0] clen_q;
  wire                  c_wr_w = cmd_mode_w && uif.rx_valid && (clen_q < CMD_MAX);
  for (genvar g = 0; g < CMD_MAX; g++) begin : g_cbuf
    always_ff @(posedge i_clk) begin
      if (!i_rst_b)                           cbuf_q[g] <= 8'h00;
      else if (c_wr_w && clen_q == CMD_IDX_W'(g)) cbuf_q[g] <= uif.rx_data;
    end
  end

  // Decode of a completed frame
  wire [31:0] hdr_w = {cbuf_q[0], cbuf_q[1], cbuf_q[2], cbuf_q[3]};
  wire [23:0] op_w  = {cbuf_q[4], cbuf_q[5], cbuf_q[6]};
  wire        hdr_ok_w  = (hdr_w == HDR_TTM) && (clen_q >= CMD_LEN_MIN);
  wire        is_bps_w  = hdr_ok_w && op_w == OP_BPS && cbuf_q[7] == CH_DASH
                          && clen_q == CMD_LEN_MIN && cbuf_q[8] <= BPS_MAX;
  wire        is_rst_w  = hdr_ok_w && op_w == OP_RSS;
  wire        is_mac_w  = hdr_ok_w && op_w == OP_MAC && cbuf_q[8] == CH_QUERY;
  wire        frame_end = cmd_mode_w && uif.gap && (clen_q != '0);

  // --------------------------------------------------------------------------
  // Reply sequencer
  // --------------------------------------------------------------------------
  logic [1:0] rsp_sel_q;   // 0 none, 1 ok, 2 error, 3 query
  logic [3:0] rsp_idx_q;
  wire  [3:0] rsp_len_w = (rsp_sel_q == 2'd1) ? 4'(OK_LEN) :
                          (rsp_sel_q == 2'd2) ? 4'(ERR_LEN) : 4'(MAC_LEN);
  wire  [7:0] ok_byte_w  = RSP_OK[8*(OK_LEN-1-32'(rsp_idx_q)) +: 8];
  wire  [7:0] err_byte_w = RSP_ERR[8*(ERR_LEN-1-32'(rsp_idx_q)) +: 8];
  wire  [7:0] mac_byte_w = MAC_ADDR_RST[8*(MAC_LEN-1-32'(rsp_idx_q)) +: 8];
  wire        rsp_busy_w = (rsp_sel_q != 2'd0);
  assign tx_data_w  = (rsp_sel_q == 2'd1) ? ok_byte_w :
                      (rsp_sel_q == 2'd2) ? err_byte_w : mac_byte_w;
  assign tx_valid_w = rsp_busy_w && uif.tx_ready;
  wire        last_w = tx_valid_w && (rsp_idx_q == rsp_len_w - 4'h1);

  // Frame decode, reply start and setting updates
  always_ff @(posedge i_clk) begin
    commit_q <= 1'b0;
    if (!i_rst_b) begin
      clen_q <= '0; rsp_sel_q <= 2'd0; rsp_idx_q <= '0;
      baud_q <= BAUD_CODE_RST; baud_pend_q <= BAUD_CODE_RST;
    end else begin
      if (!cmd_mode_w) clen_q <= '0;
      else if (frame_end) clen_q <= '0;
      else if (c_wr_w) clen_q <= clen_q + 1'b1;
      if (frame_end && !rsp_busy_w) begin
        rsp_idx_q <= '0;
        if (is_bps_w) begin
          baud_pend_q <= cbuf_q[8][2:0];
          rsp_sel_q   <= 2'd1;
        end else if (is_rst_w) begin
          baud_q   <= baud_pend_q;
          commit_q <= 1'b1;
        end else if (is_mac_w) rsp_sel_q <= 2'd3;
        else rsp_sel_q <= 2'd2;
      end else if (!uart_on_w) rsp_sel_q <= 2'd0;
      else if (last_w) rsp_sel_q <= 2'd0;
      else if (tx_valid_w) rsp_idx_q <= rsp_idx_q + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Transparent path to the radio: eight-entry shift queue
  // --------------------------------------------------------------------------
  // Entry 0 is the head, so the byte offered to the radio comes straight
  // from a flip-flop; the price is a shift of every entry on each pop.
  logic [7:0]                 lq_q [LINK_FIFO_FULL];
  logic [LINK_FIFO_CNT_W-1:0] occ_q;
  logic                       lvalid_q, full_q, ind_q, tx_q;
  wire push_w = pass_w && uif.rx_valid && !full_q;
  wire pop_w  = lvalid_q && i_link_ready;
  wire [LINK_FIFO_CNT_W-1:0] occ_nx_w = occ_q + {3'h0, push_w} - {3'h0, pop_w};
  // A pop in the same cycle moves the tail down by one slot
  wire [LINK_FIFO_CNT_W-1:0] wr_at_w  = occ_q - {3'h0, pop_w};

  // One generate entry per queue slot
  for (genvar e = 0; e < LINK_FIFO_FULL; e++) begin : g_lq
    always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
        lq_q[e] <= 8'h00;
      end else if (push_w && wr_at_w == LINK_FIFO_CNT_W'(e)) begin
        lq_q[e] <= uif.rx_data;
      end else if (pop_w) begin
        // Top slot takes a stale value; it lies beyond the count then
        lq_q[e] <= lq_q[(e + 1) % LINK_FIFO_FULL];
      end
    end
  end

  // Count, valid and pin flops
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      occ_q <= '0; lvalid_q <= 1'b0;
      full_q <= 1'b0; ind_q <= 1'b0; tx_q <= 1'b1;
    end else begin
      occ_q    <= occ_nx_w;
      lvalid_q <= (occ_nx_w != '0);
      // Host sees full before the queue can overflow
      full_q   <= (occ_nx_w >= LINK_FIFO_FULL);
      ind_q    <= (mode_d == BUH_CONN);
      tx_q     <= tx_pin_w;
    end
  end
  assign o_link_valid         = lvalid_q;
  assign o_link_data          = lq_q[0];
  assign o_buffer_full        = full_q;
  assign o_link_indicator_out = ind_q;
  assign o_uart_tx            = tx_q;
  assign o_baud_code          = baud_q;
  assign o_commit             = commit_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_ind_conn: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_link_indicator_out |-> $past(link_w && !sleep_w))
    else $error("link indicator does not follow connection");
  a_sleep_ind: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sleep_w |=> ##1 !o_link_indicator_out)
    else $error("indicator high during sleep");
  a_tx_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !uart_on_w ##1 !uart_on_w |=> o_uart_tx)
    else $error("tx not idle while path off");
  a_no_cmd_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !uart_on_w |=> clen_q == '0)
    else $error("command bytes kept while path off");
  a_baud_defer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $changed(baud_q) |-> $past(commit_q == 1'b0) && $past(frame_end && is_rst_w))
    else $error("baud changed without reset command");
  a_commit_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_commit |=> !o_commit)
    else $error("commit longer than one cycle");
  a_full_stops: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    occ_q >= LINK_FIFO_FULL |-> o_buffer_full)
    else $error("buffer full not shown");
  a_ok_first: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    tx_valid_w && rsp_sel_q == 2'd1 && rsp_idx_q == 4'h0 |-> tx_data_w == 8'h54)
    else $error("success reply starts wrong");
  a_pass_push: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    push_w && occ_q == '0 |=> o_link_valid && o_link_data == $past(uif.rx_data))
    else $error("passthrough byte lost");
  // Offered byte must stand until the radio takes it
  a_link_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_link_valid && !i_link_ready |=> o_link_valid && $stable(o_link_data))
    else $error("link byte changed before taken");
  // Each command byte lands in the next buffer slot
  a_cmd_count: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    c_wr_w |=> clen_q == $past(clen_q) + 5'h01)
    else $error("command byte not stored");
  // Serial-enable has no effect while asleep
  a_sleep_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sleep_w |-> !uif.enable)
    else $error("serial path on while asleep");
  // Full is low only while a slot is free
  a_full_level: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !o_buffer_full |-> occ_q < LINK_FIFO_FULL)
    else $error("buffer full missing");
  c_conn: cover property (@(posedge i_clk) mode_q == BUH_ADV ##1 mode_q == BUH_CONN);
  c_ok:   cover property (@(posedge i_clk) last_w && rsp_sel_q == 2'd1);
  c_err:  cover property (@(posedge i_clk) last_w && rsp_sel_q == 2'd2);
  c_full: cover property (@(posedge i_clk) $rose(o_buffer_full));
  c_mac:  cover property (@(posedge i_clk) last_w && rsp_sel_q == 2'd3);

endmodule // buh_ctrl

// [design/buh_pkg.sv]
// Constants and types for the serial bridge host control block.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package buh_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned BAUD_DIV_W   = 16;
  // Bit time per baud code 0..4: 9600/19200/38400/57600/115200
  localparam logic [BAUD_DIV_W-1:0] BIT_CYC_0 = BAUD_DIV_W'(CLK_HZ / 9600);
  localparam logic [BAUD_DIV_W-1:0] BIT_CYC_1 = BAUD_DIV_W'(CLK_HZ / 19200);
  localparam logic [BAUD_DIV_W-1:0] BIT_CYC_2 = BAUD_DIV_W'(CLK_HZ / 38400);
  localparam logic [BAUD_DIV_W-1:0] BIT_CYC_3 = BAUD_DIV_W'(CLK_HZ / 57600);
  localparam logic [BAUD_DIV_W-1:0] BIT_CYC_4 = BAUD_DIV_W'(CLK_HZ / 115200);
  localparam logic [2:0]            BAUD_CODE_RST = 3'h0;

  // --------------------------------------------------------------------------
  // Command framing: "TTM:" header, 3-letter op, '-', parameter; reset is "TTM:RSSYS" with no '-'
  // --------------------------------------------------------------------------
  localparam logic [31:0] HDR_TTM   = 32'h5454_4D3A;
  localparam logic [23:0] OP_BPS    = 24'h4250_53;
  localparam logic [23:0] OP_RSS    = 24'h5253_53;   // Reset ("RSS" then "YS")
  localparam logic [23:0] OP_MAC    = 24'h4D41_43;
  localparam logic [7:0]  CH_DASH   = 8'h2D;
  localparam logic [7:0]  CH_QUERY  = 8'h3F;
  localparam int unsigned CMD_MAX   = 16;            // Bytes buffered per command
  localparam int unsigned CMD_IDX_W = 5;
  localparam logic [CMD_IDX_W-1:0] CMD_LEN_MIN = 5'h09;
  localparam logic [7:0]  BPS_MAX   = 8'h04;

  // Answers
  localparam int unsigned OK_LEN  = 9;
  localparam int unsigned ERR_LEN = 10;
  localparam logic [8*OK_LEN-1:0]  RSP_OK  = 72'h54_544D_3A4F_4B0D_0A00;
  localparam logic [8*ERR_LEN-1:0] RSP_ERR = 80'h5454_4D3A_4552_500D_0A00;
  localparam int unsigned MAC_LEN = 6;
  localparam logic [47:0] MAC_ADDR_RST = 48'h0000_0000_0001; // Arbitrary value

  // Idle gap that closes a command frame, in bit times
  localparam logic [3:0] GAP_BITS = 4'h3;
  localparam logic [3:0] FRAME_BITS = 4'h9;           // Start + 8 data

  // Buffer-full threshold for outgoing link traffic
  localparam int unsigned LINK_FIFO_CNT_W = 4;
  localparam logic [LINK_FIFO_CNT_W-1:0] LINK_FIFO_FULL = 4'h8;

  typedef enum logic [1:0] {BUH_SLEEP, BUH_ADV, BUH_CONN} buh_mode_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} buh_tx_st_t;

endpackage : buh_pkg

// [design/buh_uart.sv]
// 8N1 UART receiver and transmitter with programmable bit time.
// Assumes i_rx already synchronised to i_clk.
module buh_uart (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Serial pins
  input  wire logic i_rx,
  output logic      o_tx,
  // Byte side
  buh_uart_if.core  u
);
  import buh_pkg::*;

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  logic [BAUD_DIV_W-1:0] rcnt_q;
  logic [3:0]            rbit_q;
  logic [7:0]            rsh_q;
  logic                  rbusy_q;
  logic [3:0]            idle_q;
  logic                  pend_q;
  logic                  rvalid_q;
  logic                  gap_q;
  wire                   r_tick  = (rcnt_q == '0);
  wire  [BAUD_DIV_W-1:0] r_half  = u.bit_cyc >> 1;
  wire                   r_start = u.enable && !rbusy_q && !i_rx;

  // Mid-bit sampling; bytes are dropped while disabled
  always_ff @(posedge i_clk) begin
    rvalid_q <= 1'b0;
    gap_q    <= 1'b0;
    if (!i_rst_b || !u.enable) begin
      rbusy_q <= 1'b0; rcnt_q <= '0; rbit_q <= '0; rsh_q <= '0;
      idle_q <= '0; pend_q <= 1'b0;
    end else if (r_start) begin
      rbusy_q <= 1'b1; rcnt_q <= r_half; rbit_q <= '0;
    end else if (rbusy_q) begin
      rcnt_q <= r_tick ? u.bit_cyc - 1'b1 : rcnt_q - 1'b1;
      if (r_tick) begin
        rbit_q <= rbit_q + 1'b1;
        // Shift data bits only; the stop sample must not push bit 0 out
        if (rbit_q != '0 && rbit_q != FRAME_BITS) rsh_q <= {i_rx, rsh_q[7:1]};
        if (rbit_q == FRAME_BITS) begin
          rbusy_q  <= 1'b0;
          rvalid_q <= i_rx;       // Stop bit must be high
          pend_q   <= 1'b1;
          idle_q   <= '0;
          rcnt_q   <= u.bit_cyc;
        end
      end
    end else if (pend_q) begin
      // Quiet line marks end of a command frame
      rcnt_q <= r_tick ? u.bit_cyc : rcnt_q - 1'b1;
      if (r_tick) begin
        idle_q <= idle_q + 1'b1;
        if (idle_q == GAP_BITS) begin
          gap_q  <= 1'b1;
          pend_q <= 1'b0;
        end
      end
    end
  end
  assign u.rx_valid = rvalid_q;
  assign u.rx_data  = rsh_q;
  assign u.gap      = gap_q;

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  buh_tx_st_t            tst_q;
  logic [BAUD_DIV_W-1:0] tcnt_q;
  logic [2:0]            tbit_q;
  logic [7:0]            tsh_q;
  logic                  tx_q;
  wire                   t_tick = (tcnt_q == '0);

  // Line idles high whenever the path is off
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !u.enable) begin
      tst_q <= TX_IDLE; tcnt_q <= '0; tbit_q <= '0; tsh_q <= '0; tx_q <= 1'b1;
    end else begin
      tcnt_q <= t_tick ? u.bit_cyc - 1'b1 : tcnt_q - 1'b1;
      case (tst_q)
        TX_IDLE: begin
          tx_q <= 1'b1;
          if (u.tx_valid) begin
            tsh_q <= u.tx_data; tst_q <= TX_START; tcnt_q <= u.bit_cyc - 1'b1;
            tx_q <= 1'b0;
          end
        end
        TX_START: if (t_tick) begin
          tst_q <= TX_DATA; tx_q <= tsh_q[0]; tbit_q <= '0;
        end
        TX_DATA: if (t_tick) begin
          tbit_q <= tbit_q + 1'b1;
          tsh_q  <= tsh_q >> 1;
          tx_q   <= (tbit_q == 3'h7) ? 1'b1 : tsh_q[1];
          if (tbit_q == 3'h7) tst_q <= TX_STOP;
        end
        default: if (t_tick) tst_q <= TX_IDLE;
      endcase
    end
  end
  assign u.tx_ready = (tst_q == TX_IDLE);
  assign o_tx       = tx_q;

endmodule // buh_uart

// [design/buh_uart_if.sv]
// Interface carrying serial timing and byte handshakes to the UART core.
// Assumes both ends share i_clk.
interface buh_uart_if;
  import buh_pkg::*;
  logic [BAUD_DIV_W-1:0] bit_cyc;   // Cycles per bit
  logic                  enable;    // UART path active
  logic                  rx_valid;  // One-cycle pulse per received byte
  logic [7:0]            rx_data;
  logic                  gap;       // One-cycle pulse: line idle after bytes
  logic                  tx_valid;
  logic [7:0]            tx_data;
  logic                  tx_ready;
  modport core (input bit_cyc, enable, tx_valid, tx_data,
                output rx_valid, rx_data, gap, tx_ready);
  modport ctrl (output bit_cyc, enable, tx_valid, tx_data,
                input rx_valid, rx_data, gap, tx_ready);
endinterface : buh_uart_if
